// file: rtl/mag_threshold_detector.sv
// magnetic threshold event detector with its register set
//
// Function
// - With combine mode 0 an event needs every enabled axis at or below its threshold.
// - With combine mode 1 an event needs any enabled axis at or above its threshold.
// - The event flag rises only once the debounce counter has counted up to the debounce count.
// - With latch off the flag follows the live result and drops when it lapses.
// - With latch on the flag holds until software reads the source register.
// - Only axes whose enable bit (z 5, y 4, x 3) is set take part.
// - The flag reaches the wake logic only when config bit 2 is set.
// - The flag reaches an interrupt pin only when config bit 1 is set.
// - Config bit 0 routes the flag to the second pin when 0 and the first when 1, ORed with others.
// - Each threshold is an unsigned 15-bit magnitude.
// - Thresholds are compared with the raw sample, before any offset is removed.
// - A lapse clears the counter when the clear-mode bit is 1 and steps it down by one when 0.
// - Source holds per-axis event and polarity flags, zero for disabled axes.
// - The source event-active bit shows the debounced, possibly latched event flag.
`timescale 1ns/1ps
module mag_threshold_detector #(
    parameter int SAMPLE_W = 16,
    parameter int CNT_W    = 8
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire logic [7:0]          i_reg_addr,
    input  wire logic                i_reg_wr,
    input  wire logic                i_reg_rd,
    input  wire logic [7:0]          i_reg_wdata,
    output logic      [7:0]          o_reg_rdata,
    input  wire logic                i_sample_valid,
    input  wire logic [SAMPLE_W-1:0] i_mag_x,
    input  wire logic [SAMPLE_W-1:0] i_mag_y,
    input  wire logic [SAMPLE_W-1:0] i_mag_z,
    input  wire logic                i_first_int_others,
    input  wire logic                i_second_int_others,
    output logic                     o_first_int,
    output logic                     o_second_int,
    output logic                     o_wake_event,
    output logic                     o_event_flag
);
    localparam int AX = mag_ths_pkg::AXES;
    localparam int TW = mag_ths_pkg::THS_W;

    // parameter sanity
    if (SAMPLE_W < 16 || SAMPLE_W > 32)
        $error("sample width must be 16 to 32");
    if (CNT_W < 1 || CNT_W > 8)
        $error("debounce width must be 1 to 8");

    typedef struct packed {
        logic [7:0]            cfg;
        logic [AX-1:0][TW-1:0] thr;
        logic                  dbclr;
        logic [CNT_W-1:0]      limit;
        logic                  flag;
        logic [2*AX-1:0]       src_axes;
        logic                  eval;
        logic [7:0]            rdata;
    } det_s;
    det_s q;
    det_s d;

    logic [AX-1:0][SAMPLE_W-1:0] samples;
    logic [AX-1:0]               above;
    logic [AX-1:0]               below;
    logic [AX-1:0]               neg;
    logic [AX-1:0]               en;
    logic [AX-1:0]               axis_hit;
    logic                        cond;
    logic                        met;
    logic [CNT_W-1:0]            count;
    logic                        src_read;
    logic                        int_evt;

    // per-axis hit mask pattern for the source register layout
    function automatic logic [2*AX-1:0] spread(input logic [AX-1:0] m);
        logic [2*AX-1:0] r;
        r = '0;
        for (int k = 0; k < AX; k++)
        begin
            r[2*k]   = m[k];
            r[2*k+1] = m[k];
        end
        return r;
    endfunction : spread

    // raw samples go straight in; offset removal happens elsewhere
    assign samples = {i_mag_z, i_mag_y, i_mag_x};
    assign en      = q.cfg[mag_ths_pkg::CFG_XEN_BIT +: AX];

    for (genvar g = 0; g < AX; g++)
    begin : g_axis
        mag_axis_compare #(
            .SAMPLE_W (SAMPLE_W)
        ) u_cmp (
            .i_sample      (samples[g]),
            .i_threshold   (q.thr[g]),
            .o_at_or_above (above[g]),
            .o_at_or_below (below[g]),
            .o_negative    (neg[g])
        );
    end

    // combine enabled axes; no axis enabled means no event
    always_comb
    begin
        if (q.cfg[mag_ths_pkg::CFG_OR_BIT])
        begin
            axis_hit = above & en;
            cond     = |axis_hit;
        end
        else
        begin
            axis_hit = below & en;
            cond     = (&(below | ~en)) && (|en);
        end
    end

    mag_debounce #(
        .CNT_W (CNT_W)
    ) u_deb (
        .i_clk          (i_clk),
        .i_rst          (i_rst),
        .i_sample_valid (i_sample_valid),
        .i_cond         (cond),
        .i_limit        (q.limit),
        .i_clear_mode   (q.dbclr),
        .o_met          (met),
        .o_count        (count)
    );

    assign src_read = i_reg_rd && (i_reg_addr == mag_ths_pkg::SRC_ADDR);

    // register file, event flag and source capture
    always_comb
    begin
        d      = q;
        d.eval = i_sample_valid;
        if (i_reg_wr)
        begin
            if (i_reg_addr == mag_ths_pkg::CFG_ADDR)
                d.cfg = i_reg_wdata;
            if (i_reg_addr == mag_ths_pkg::COUNT_ADDR)
                d.limit = i_reg_wdata[CNT_W-1:0];
            for (int k = 0; k < AX; k++)
            begin
                if (i_reg_addr == mag_ths_pkg::THS_BASE_ADDR + 8'(2*k))
                    d.thr[k][TW-1:8] = i_reg_wdata[TW-9:0];
                if (i_reg_addr == mag_ths_pkg::THS_BASE_ADDR + 8'(2*k+1))
                    d.thr[k][7:0] = i_reg_wdata;
            end
            if (i_reg_addr == mag_ths_pkg::THS_BASE_ADDR)
                d.dbclr = i_reg_wdata[mag_ths_pkg::THS_CLR_BIT];
        end
        // per-axis flags follow each sample unless a latched event froze them
        if (i_sample_valid && !(q.cfg[mag_ths_pkg::CFG_LATCH_BIT] && q.flag))
            d.src_axes = spread(axis_hit) & {AX{1'b1, 1'b0}} | spread(neg & axis_hit) & {AX{1'b0, 1'b1}};
        if (q.cfg[mag_ths_pkg::CFG_LATCH_BIT])
        begin
            if (src_read)
                d.flag = 1'b0;
            if (q.eval && met)
                d.flag = 1'b1;
        end
        else
            d.flag = met;
        // read data, captured on the read strobe
        if (i_reg_rd)
        begin
            d.rdata = 8'h00;
            if (i_reg_addr == mag_ths_pkg::CFG_ADDR)
                d.rdata = q.cfg;
            if (i_reg_addr == mag_ths_pkg::SRC_ADDR)
                d.rdata = {q.flag, 1'b0, q.src_axes & spread(en)};
            if (i_reg_addr == mag_ths_pkg::COUNT_ADDR)
                d.rdata = 8'(q.limit);
            for (int k = 0; k < AX; k++)
            begin
                if (i_reg_addr == mag_ths_pkg::THS_BASE_ADDR + 8'(2*k))
                    d.rdata = {(k == 0) ? q.dbclr : 1'b0, q.thr[k][TW-1:8]};
                if (i_reg_addr == mag_ths_pkg::THS_BASE_ADDR + 8'(2*k+1))
                    d.rdata = q.thr[k][7:0];
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            q       <= '0;
            q.cfg   <= mag_ths_pkg::CFG_RESET;
            q.thr   <= {AX{mag_ths_pkg::THS_RESET}};
            q.limit <= CNT_W'(mag_ths_pkg::COUNT_RESET);
        end
        else
            q <= d;
    end

    // outputs: wake, interrupt routing with the other sources
    assign int_evt      = q.flag && q.cfg[mag_ths_pkg::CFG_INTEN_BIT];
    assign o_first_int  = i_first_int_others | (int_evt & q.cfg[mag_ths_pkg::CFG_ROUTE_BIT]);
    assign o_second_int = i_second_int_others | (int_evt & ~q.cfg[mag_ths_pkg::CFG_ROUTE_BIT]);
    assign o_wake_event = q.flag && q.cfg[mag_ths_pkg::CFG_WAKE_BIT];
    assign o_event_flag = q.flag;
    assign o_reg_rdata  = q.rdata;

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    cfg_reset_zero_a: assert property (@(posedge i_clk) disable iff (1'b0) i_rst |=> q.cfg == 8'h00)
        else $error("config not zero after reset");
    and_mode_block_a: assert property (i_sample_valid && !q.cfg[6] && |(en & ~below) |=> !met)
        else $error("and mode event with an axis above threshold");
    or_mode_fire_a: assert property (i_sample_valid && q.cfg[6] && q.limit == '0 && |(en & above) |=> met)
        else $error("or mode missed an axis at threshold");
    debounce_gate_a: assert property ($rose(met) |-> count >= q.limit)
        else $error("event before debounce count reached");
    live_track_a: assert property (!q.cfg[7] && !met ##1 !q.cfg[7] |-> !q.flag)
        else $error("unlatched flag outlived the condition");
    latch_hold_a: assert property (q.cfg[7] && q.flag && !src_read && !i_reg_wr |=> q.flag)
        else $error("latched flag dropped without a source read");
    no_axis_a: assert property (i_sample_valid && en == '0 |=> !met)
        else $error("event with every axis disabled");
    wake_gate_a: assert property (!q.cfg[2] |-> !o_wake_event)
        else $error("wake event while excluded");
    int_gate_a: assert property (!q.cfg[1] && !i_second_int_others && !i_first_int_others |-> !o_first_int && !o_second_int)
        else $error("interrupt while disabled");
    route_first_a: assert property (q.flag && q.cfg[1] && q.cfg[0] && !i_second_int_others |-> o_first_int && !o_second_int)
        else $error("event on wrong interrupt pin");
    step_down_a: assert property (i_sample_valid && !cond && !q.dbclr && count != '0 |=> count == $past(count) - CNT_W'(1))
        else $error("debounce counter did not step down");
    clear_mode_a: assert property (i_sample_valid && !cond && q.dbclr |=> count == '0)
        else $error("debounce counter not cleared");
    src_mask_a: assert property (src_read && !i_reg_wr && en == '0 |=> o_reg_rdata[5:0] == 6'h00)
        else $error("disabled axis shows in source");
    ea_bit_a: assert property (src_read |=> o_reg_rdata[7] == $past(q.flag))
        else $error("event-active bit disagrees with flag");
    count_up_a: assert property (i_sample_valid && cond && count < q.limit && !i_reg_wr |=> count == $past(count) + CNT_W'(1))
        else $error("debounce counter did not count up");

    latched_event_c: cover property (q.cfg[7] && q.flag ##1 src_read ##1 !q.flag);
    or_event_c: cover property (q.cfg[6] && $rose(q.flag));
    and_event_c: cover property (!q.cfg[6] && q.limit > '0 && $rose(q.flag));
    first_pin_c: cover property ($rose(o_first_int));
endmodule : mag_threshold_detector

// file: include/mag_ths_pkg.sv
// constants for the magnetic threshold detector
package mag_ths_pkg;
    // register offsets on the serial register port
    localparam logic [7:0] CFG_ADDR      = 8'h52;
    localparam logic [7:0] SRC_ADDR      = 8'h53;
    localparam logic [7:0] THS_BASE_ADDR = 8'h54;
    localparam logic [7:0] COUNT_ADDR    = 8'h5f;
    // configuration field positions
    localparam int CFG_LATCH_BIT = 7;
    localparam int CFG_OR_BIT    = 6;
    localparam int CFG_XEN_BIT   = 3;
    localparam int CFG_WAKE_BIT  = 2;
    localparam int CFG_INTEN_BIT = 1;
    localparam int CFG_ROUTE_BIT = 0;
    // source and threshold field positions
    localparam int SRC_EA_BIT    = 7;
    localparam int THS_CLR_BIT   = 7;
    localparam int AXES          = 3;
    localparam int THS_W         = 15;
    // reset values
    localparam logic [7:0]       CFG_RESET   = 8'h00;
    localparam logic [THS_W-1:0] THS_RESET   = 15'h0000;
    localparam logic [7:0]       COUNT_RESET = 8'h00;
endpackage : mag_ths_pkg

// file: rtl/mag_axis_compare.sv
// one axis: magnitude of a raw sample against an unsigned threshold
`timescale 1ns/1ps
module mag_axis_compare #(
    parameter int SAMPLE_W = 16
) (
    input  wire logic [SAMPLE_W-1:0]          i_sample,
    input  wire logic [mag_ths_pkg::THS_W-1:0] i_threshold,
    output logic                              o_at_or_above,
    output logic                              o_at_or_below,
    output logic                              o_negative
);
    logic [SAMPLE_W-1:0] mag;
    logic [SAMPLE_W-1:0] thr_ext;

    // magnitude as unsigned, so full negative scale stays exact
    always_comb
    begin
        o_negative    = i_sample[SAMPLE_W-1];
        mag           = o_negative ? SAMPLE_W'(-i_sample) : i_sample;
        thr_ext       = SAMPLE_W'(i_threshold);
        o_at_or_above = (mag >= thr_ext);
        o_at_or_below = (mag <= thr_ext);
    end
endmodule : mag_axis_compare

// file: rtl/mag_debounce.sv
// debounce counter for the combined threshold condition
`timescale 1ns/1ps
module mag_debounce #(
    parameter int CNT_W = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_sample_valid,
    input  wire logic             i_cond,
    input  wire logic [CNT_W-1:0] i_limit,
    input  wire logic             i_clear_mode,
    output logic                  o_met,
    output logic [CNT_W-1:0]      o_count
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             met;
    } deb_s;
    deb_s q;
    deb_s d;

    // count up while true, clear or step down when it lapses
    always_comb
    begin
        d = q;
        if (i_sample_valid)
        begin
            if (i_cond)
            begin
                if (q.cnt < i_limit)
                    d.cnt = q.cnt + CNT_W'(1);
                d.met = (d.cnt >= i_limit);
            end
            else
            begin
                if (i_clear_mode)
                    d.cnt = '0;
                else if (q.cnt != '0)
                    d.cnt = q.cnt - CNT_W'(1);
                d.met = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            q <= '0;
        else
            q <= d;
    end

    assign o_met   = q.met;
    assign o_count = q.cnt;
endmodule : mag_debounce

// file: verif/mag_host_model.sv
// host-side register master that reaches the detector's register port
`timescale 1ns/1ps
module mag_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_reg_rdata,
    output logic      [7:0] o_reg_addr,
    output logic            o_reg_wr,
    output logic            o_reg_rd,
    output logic      [7:0] o_reg_wdata
);
    // idle bus from time zero
    initial
    begin
        o_reg_addr  = 8'h00;
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_wdata = 8'h00;
    end
    // one-cycle write strobe, then address and data scrambled so stale values never look valid
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        o_reg_wr    <= 1'b1;
        o_reg_addr  <= addr;
        o_reg_wdata <= data;
        @(posedge i_clk);
        o_reg_wr    <= 1'b0;
        o_reg_addr  <= ~addr;
        o_reg_wdata <= ~data;
    endtask : wr
    // one-cycle read strobe; data is taken in the cycle after the strobe edge
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_clk);
        o_reg_rd   <= 1'b1;
        o_reg_addr <= addr;
        @(posedge i_clk);
        o_reg_rd   <= 1'b0;
        o_reg_addr <= ~addr;
        @(posedge i_clk);
        #1 data = i_reg_rdata;
    endtask : rd
endmodule : mag_host_model

// file: verif/tb_mag_threshold_detector.sv
// self-checking bench for the magnetic threshold detector
`timescale 1ns/1ps
module tb_mag_threshold_detector;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  addr, wdata, rdata, got, cfg;
    logic        wr, rd, oth1 = 1'b0, oth2 = 1'b0, valid = 1'b0, f;
    logic [15:0] mx = 16'h0000, my = 16'h0000, mz = 16'h0000;
    logic        first_int, second_int, wake, flag;
    logic [15:0] smp [3];
    logic [14:0] thr [3];
    int          miscompares = 0, n_compared = 0, cycles = 0;
    localparam logic [9:0] DB_HIGH = 10'b1011101110; // condition true, index 0 first
    localparam logic [9:0] DB_FLAG = 10'b1010001000;

    mag_threshold_detector u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sample_valid(valid), .i_mag_x(mx),
        .i_mag_y(my), .i_mag_z(mz), .i_first_int_others(oth1), .i_second_int_others(oth2),
        .o_first_int(first_int), .o_second_int(second_int), .o_wake_event(wake), .o_event_flag(flag));
    mag_host_model u_host (.i_clk(i_clk), .i_reg_rdata(rdata), .o_reg_addr(addr), .o_reg_wr(wr),
        .o_reg_rd(rd), .o_reg_wdata(wdata));

    // 25 MHz clock
    always #20 i_clk = ~i_clk;
    // hang guard
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            miscompares++;
            report_and_stop();
        end
    end
    // counts and verdict
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] seen, input logic [7:0] want, input string what);
        n_compared++;
        if (seen !== want)
        begin
            miscompares++;
            $display("MISMATCH %0t %s: seen %h want %h", $time, what, seen, want);
        end
    endtask : chk
    // magnitude of a raw signed sample against an unsigned threshold
    function automatic logic pass(input logic mode, input logic [15:0] s, input logic [14:0] t);
        logic [16:0] m;
        m = s[15] ? 17'h10000 - {1'b0, s} : {1'b0, s};
        return mode ? (m >= {2'h0, t}) : (m <= {2'h0, t});
    endfunction : pass
    // combined condition of the enabled axes
    function automatic logic cond();
        logic [2:0] p;
        for (int k = 0; k < 3; k++)
            p[k] = pass(cfg[6], smp[k], thr[k]);
        if (cfg[5:3] == 3'h0)
            return 1'b0;
        return cfg[6] ? |(cfg[5:3] & p) : &(p | ~cfg[5:3]);
    endfunction : cond
    // source register image for the given flag
    function automatic logic [7:0] src(input logic fl);
        logic [7:0] r;
        r = {fl, 7'h00};
        for (int k = 0; k < 3; k++)
        begin
            r[2*k+1] = cfg[3+k] & pass(cfg[6], smp[k], thr[k]);
            r[2*k]   = r[2*k+1] & smp[k][15];
        end
        return r;
    endfunction : src
    task automatic put_thr(input logic clr_mode);
        for (int k = 0; k < 3; k++)
        begin
            u_host.wr(mag_ths_pkg::THS_BASE_ADDR + 8'(2*k), {k == 0 ? clr_mode : 1'b0, thr[k][14:8]});
            u_host.wr(mag_ths_pkg::THS_BASE_ADDR + 8'(2*k+1), thr[k][7:0]);
        end
    endtask : put_thr
    // one sample pulse, then wait for the flag two cycles after the sample edge
    task automatic send();
        @(posedge i_clk);
        valid <= 1'b1;
        mx    <= smp[0];
        my    <= smp[1];
        mz    <= smp[2];
        @(posedge i_clk);
        valid <= 1'b0;
        mx    <= ~smp[0];
        my    <= ~smp[1];
        mz    <= ~smp[2];
        repeat (2) @(posedge i_clk);
        #1;
    endtask : send

    initial
    begin
        void'($urandom(32'h54dd));
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        // reset values and unmapped place
        u_host.rd(mag_ths_pkg::CFG_ADDR, got);
        chk(got, 8'h00, "cfg reset");
        u_host.rd(mag_ths_pkg::SRC_ADDR, got);
        chk(got, 8'h00, "src reset");
        u_host.wr(8'h60, 8'h5a);
        u_host.rd(8'h60, got);
        chk(got, 8'h00, "unmapped");
        // debounce in and mode, then or mode: leading lapse clears the counter, step-down from the ninth sample
        thr = '{15'd100, 15'd0, 15'd0};
        for (int m = 0; m < 2; m++)
        begin
            cfg = m[0] ? 8'h48 : 8'h08;
            u_host.wr(mag_ths_pkg::CFG_ADDR, cfg);
            u_host.wr(mag_ths_pkg::COUNT_ADDR, 8'h03);
            put_thr(1'b1);
            for (int i = 0; i < 10; i++)
            begin
                if (i == 8)
                    put_thr(1'b0);
                smp = '{(DB_HIGH[i] == m[0]) ? 16'd200 : 16'd5, 16'h0000, 16'h0000};
                send();
                chk({7'h0, flag}, {7'h0, DB_FLAG[i]}, "debounce flag");
            end
        end
        // latched flag survives a lapse and clears on a source read
        cfg = 8'hcb;
        u_host.wr(mag_ths_pkg::COUNT_ADDR, 8'h00);
        u_host.wr(mag_ths_pkg::CFG_ADDR, cfg);
        u_host.rd(mag_ths_pkg::SRC_ADDR, got);
        chk(got, 8'h82, "source before clear");
        chk({7'h0, flag}, 8'h00, "clear before latch");
        smp = '{16'd200, 16'h0000, 16'h0000};
        send();
        chk({7'h0, first_int}, 8'h01, "latched pin");
        smp = '{16'd5, 16'h0000, 16'h0000};
        send();
        chk({7'h0, flag}, 8'h01, "latched hold");
        u_host.rd(mag_ths_pkg::SRC_ADDR, got);
        chk(got, 8'h82, "latched source");
        chk({7'h0, flag}, 8'h00, "cleared by read");
        // random configurations, thresholds and raw samples, corner values first
        for (int i = 0; i < 160; i++)
        begin
            cfg = {1'b0, 7'($urandom)};
            for (int k = 0; k < 3; k++)
            begin
                thr[k] = (i < 4) ? 15'h7fff : 15'($urandom);
                smp[k] = (i < 4) ? (i[0] ? 16'h8000 : 16'h7fff) : 16'($urandom);
            end
            if (i < 4)
                cfg[6] = i[1];
            u_host.wr(mag_ths_pkg::CFG_ADDR, cfg);
            u_host.rd(mag_ths_pkg::CFG_ADDR, got);
            chk(got, cfg, "cfg readback");
            put_thr(1'b0);
            oth1 <= 1'($urandom);
            oth2 <= 1'($urandom);
            send();
            f = cond();
            chk({7'h0, flag}, {7'h0, f}, "live flag");
            chk({5'h0, first_int, second_int, wake}, {5'h0, oth1 | (cfg[1] & cfg[0] & f),
                oth2 | (cfg[1] & ~cfg[0] & f), cfg[2] & f}, "pins");
            u_host.rd(mag_ths_pkg::SRC_ADDR, got);
            chk(got, src(f), "source");
        end
        report_and_stop();
    end
endmodule : tb_mag_threshold_detector
